//--- bench/spr_dev_model.sv
// Purpose : behavioural speech processor on the host bus
// Assumes : strobes active low, bus level resolved here for both parties
// Notes   : fifo drains one byte every DRAIN+1 cycles while talking
`timescale 1ns/1ps
module spr_dev_model #(
    parameter int         DRAIN     = 400,   // cycles per consumed byte, less one
    parameter logic [7:0] DATA_BYTE = 8'hA5  // byte held in data register
) (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       slow,            // long answer time when high
    input  wire logic       write_select_n,
    input  wire logic       read_select_n,
    input  wire logic       busOe,
    input  wire logic [7:0] busOut,
    output logic [7:0]      busIn,           // resolved bus level
    output logic            readyN,
    output logic            intN,
    output int              wrCount          // writes latched
);
    int         wt, drn, cnt, cntNext;
    logic       ext, ts, bl, be, done, wr, start, inc, dec, blNext, beNext;
    logic [2:0] cmd;
    logic [7:0] lastBus;
    // ************************************************************
    // cycle decode and fifo count
    // ************************************************************
    always_comb begin
        done    = (wt == (slow ? 12 : 3)) && !(write_select_n && read_select_n);
        wr      = done && !write_select_n;
        start   = wr && !ext && busIn[6:4] == 3'h6;
        inc     = wr && ext && cnt < 16;
        dec     = ts && drn == DRAIN;
        cntNext = start ? 0 : cnt + int'(inc) - int'(dec);
        blNext  = (ext || start) ? cntNext <= 8 : bl;
        beNext  = (ext || start) ? cntNext == 0 : be;
    end
    // released bus shows a pattern that flips every cycle
    always_comb begin
        if (!busOe) busIn = busOut;
        else if (!read_select_n && wt > 0) busIn = (cmd == 3'h1) ? DATA_BYTE : {ts, bl, be, 5'h00};
        else busIn = ~lastBus;
    end
    always_ff @(posedge ref_clk) begin
        lastBus <= rst ? 8'h00 : busIn;
        if (rst) begin
            {readyN, ext, ts, bl, be, cmd} <= '0;
            intN    <= 1'b1;
            cnt     <= 0;
            wt      <= 0;
            drn     <= 0;
            wrCount <= 0;
        end else begin
            wt <= (write_select_n && read_select_n) ? 0 : wt + 1;
            if (wt == 0 && !(write_select_n && read_select_n)) readyN <= 1'b1;
            if (done) readyN <= 1'b0;
            if (wr) wrCount <= wrCount + 1;
            if (wr && !ext) cmd <= busIn[6:4];
            cnt <= cntNext;
            bl  <= blNext;
            be  <= beNext;
            drn <= (ts && !dec) ? drn + 1 : 0;
            if (start) ext <= 1'b1;
            if (ext && cntNext >= 9) ts <= 1'b1;
            if (dec && cntNext == 0) begin
                ts  <= 1'b0;
                ext <= 1'b0;
            end
            if ((blNext && !bl) || (beNext && !be) || (start && !be)) intN <= 1'b0;
            else if (done && !read_select_n && cmd != 3'h1) intN <= 1'b1;
        end
    end
endmodule

//--- bench/spr_host_checker.sv
// Purpose : port watcher for the speech-port host controller
// Assumes : ce is held high by the bench
// Notes   : two clock domains, every property names its own clock
`timescale 1ns/1ps
module spr_host_checker (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic userValid,
    input wire logic userWrite,
    input wire logic userIsData,
    input wire logic userBusy,
    input wire logic userRefused,
    input wire logic rdValid,
    input wire logic extActive,
    input wire logic write_select_n,
    input wire logic read_select_n,
    input wire logic busOe,
    input wire logic memory_sync_clock,
    input wire logic rom_function_sel_a,
    input wire logic rom_function_sel_b,
    input wire logic nibble_msb_data_line,
    input wire logic romOe
);
    // ************************************************************
    // host bus
    // ************************************************************
    logic take;    // request accepted at this edge
    logic refuse;  // data write with no external speech running
    assign take   = ce && userValid && !userBusy;
    assign refuse = take && userWrite && userIsData && !extActive;
    a_sel_excl: assert property (@(posedge ref_clk) disable iff (rst)
        write_select_n || read_select_n) else $error("both strobes low");
    a_write_drives: assert property (@(posedge ref_clk) disable iff (rst)
        !write_select_n |-> !busOe) else $error("write without bus drive");
    a_read_floats: assert property (@(posedge ref_clk) disable iff (rst)
        !read_select_n |-> busOe) else $error("read while driving bus");
    a_refuse_pulse: assert property (@(posedge ref_clk) disable iff (rst)
        refuse |-> ##[1:2] userRefused) else $error("refusal not flagged");
    a_refuse_quiet: assert property (@(posedge ref_clk) disable iff (rst)
        refuse |=> write_select_n [*3]) else $error("refused write reached bus");
    a_take_strobe: assert property (@(posedge ref_clk) disable iff (rst)
        take && !refuse |-> ##[1:2] !(write_select_n && read_select_n))
        else $error("no strobe after request");
    a_strobe_hold: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(write_select_n) |-> !write_select_n [*3]) else $error("write strobe cut short");
    a_read_result: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(read_select_n) |-> rdValid) else $error("read ended without data");
    // ************************************************************
    // speech rom link
    // ************************************************************
    a_load_release: assert property (@(posedge memory_sync_clock) disable iff (rst)
        rom_function_sel_b && !rom_function_sel_a |=> romOe) else $error("line held on load");
    a_dummy_quiet: assert property (@(posedge memory_sync_clock) disable iff (rst)
        (rom_function_sel_b && !rom_function_sel_a) ##1 (rom_function_sel_a && !rom_function_sel_b)
        |=> romOe) else $error("dummy read drove line");
    a_idle_hold: assert property (@(posedge memory_sync_clock) disable iff (rst)
        !rom_function_sel_a && !rom_function_sel_b |=> $stable(nibble_msb_data_line)
        && $stable(romOe)) else $error("idle changed rom line");
    c_write: cover property (@(posedge ref_clk) disable iff (rst) $fell(write_select_n));
    c_read: cover property (@(posedge ref_clk) disable iff (rst) rdValid);
    c_rom_drive: cover property (@(posedge memory_sync_clock) disable iff (rst) !romOe);
endmodule

//--- bench/tb_top.sv
// Purpose : self-checking bench for the speech-port host controller
// Assumes : the bench plays the speech processor on the rom link
// Notes   : rom clock runs only inside frames
`timescale 1ns/1ps
module tb_top;
    import spr_pkg::*;
    logic ref_clk = 0, rst = 1, ce = 1, userValid = 0, userWrite = 0, userIsData = 0, slow = 0;
    logic [7:0]  userData = 8'h00, romWdata = 8'h00, busOut, busIn, rdData, q, b;
    logic        userBusy, userRefused, rdValid, extActive, intSeen, write_select_n;
    logic        read_select_n, busOe, readyN, intN, romOe, nibble_msb_data_line;
    logic        romWe = 0, memory_sync_clock = 0, rom_function_sel_a = 0, rom_function_sel_b = 0;
    logic        refSeen, rBit, rOe;
    logic [13:0] romWaddr = 14'h0000;
    logic [3:0]  nibbleIn = 4'h0, nibLast = 4'h0;
    int          wrCount, oeCnt, error_cnt = 0, check_count = 0, cycles = 0;
    spr_host dut_u (.*);
    spr_dev_model dev_u (.*);
    initial forever #20 ref_clk = ~ref_clk;
    // cycle ceiling cuts a hang short
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            results();
        end
    end
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task results;
        if (error_cnt == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // one host request, waits for the cycle to end
    task hostOp(input logic wr, input logic dat, input logic [7:0] d);
        int w;
        @(negedge ref_clk);
        {userValid, userWrite, userIsData, userData, refSeen} = {1'b1, wr, dat, d, 1'b0};
        @(negedge ref_clk);
        userValid = 0;
        w = 0;
        do begin
            refSeen |= userRefused;
            @(negedge ref_clk);
            w++;
        end while ((userBusy === 1'b1 || w < 3) && w < 300);
        q = rdData;
    endtask
    task waitInt(input int lim);
        int w;
        w = 0;
        repeat (4) @(negedge ref_clk);
        while (intSeen !== 1'b1 && w < lim) begin
            @(negedge ref_clk);
            w++;
        end
    endtask
    task romWr(input logic [13:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        {romWe, romWaddr, romWdata} = {1'b1, a, d};
        @(negedge ref_clk);
        romWe = 0;
    endtask
    // one rom clock period, released lines show inverted last level
    task romOp(input logic [1:0] fn, input logic [3:0] nib);
        {rom_function_sel_a, rom_function_sel_b} = fn;
        nibbleIn = (fn == FN_LOAD) ? nib : {romOe ? ~nibLast[3] : nibble_msb_data_line, ~nibLast[2:0]};
        nibLast = nibbleIn;
        #62.5 memory_sync_clock = 1;
        #62.5 {rBit, rOe} = {nibble_msb_data_line, romOe};
        memory_sync_clock = 0;
    endtask
    task loadAddr(input logic [19:0] a);
        for (int i = 0; i < 5; i++) romOp(FN_LOAD, a[4*i+:4]);
        romOp(FN_READ, 4'h0);
    endtask
    task romByte;
        oeCnt = 0;
        for (int i = 0; i < 8; i++) begin
            romOp(FN_READ, 4'h0);
            b = {b[6:0], rBit};
            oeCnt += int'(rOe);
        end
    endtask
    initial begin
        fork
            repeat (10) @(negedge ref_clk);
            repeat (3) romOp(FN_IDLE, 4'h0);
        join
        rst = 0;
        chk({4'h0, write_select_n, read_select_n, busOe, romOe}, 8'h0F);
        hostOp(0, 0, 8'h00); chk(q, 8'h00);
        hostOp(1, 0, 8'h10); hostOp(0, 0, 8'h00); chk(q, 8'hA5);
        slow = 1; hostOp(1, 0, 8'h00); hostOp(0, 0, 8'h00); chk(q, 8'h00);
        slow = 0; hostOp(1, 1, 8'h5A); chk({7'h00, refSeen}, 8'h01);
        chk(wrCount[7:0], 8'h02);
        hostOp(1, 0, 8'h60); repeat (4) @(negedge ref_clk);
        chk({6'h00, intSeen, extActive}, 8'h03);
        for (int i = 0; i < 9; i++) hostOp(1, 1, 8'h40 + 8'(i));
        chk(wrCount[7:0], 8'h0C);
        hostOp(0, 0, 8'h00); chk(q, 8'h80);
        waitInt(1000); chk({7'h00, intSeen}, 8'h01);
        hostOp(0, 0, 8'h00); chk(q, 8'hC0);
        waitInt(4000); hostOp(0, 0, 8'h00); chk(q, 8'h60);
        hostOp(1, 1, 8'h77); chk({6'h00, refSeen, extActive}, 8'h02);
        romWr(14'h0010, 8'hB4); romWr(14'h0011, 8'h3C); romWr(14'h0012, 8'h20);
        romWr(14'h0013, 8'h01); romWr(14'h0120, 8'h96);
        repeat (3) romOp(FN_IDLE, 4'h0);
        loadAddr(20'h00010); chk({7'h00, rOe}, 8'h01);
        romByte(); chk(b, 8'hB4); chk(oeCnt[7:0], 8'h00);
        romByte(); chk(b, 8'h3C);
        romOp(FN_BRANCH, 4'h0); romByte(); chk(b, 8'h96);
        romOp(FN_IDLE, 4'h0); loadAddr(20'h10010);
        romByte(); chk(oeCnt[7:0], 8'h08);
        results();
    end
endmodule
bind spr_host spr_host_checker chk_u (.*);

//--- verilog/spr_host.sv
// Purpose : host side of the speech processor: cpu bus master and speech rom
// Assumes : rom clock, function selects and nibble bus share the rom clock
// Notes   : rom contents are loaded through the rom image load port on ref_clk
`timescale 1ns/1ps
// Operation
// RULE1 - device joins sixteen roms with no glue
// RULE2 - msb nibble line doubles as rom data
// RULE3 - twenty bit address in five nibble loads
// RULE4 - rom byte counter advances every eight reads
// RULE5 - function selects: idle, load, read, branch
// RULE6 - load writes nibble, pointer moves four up
// RULE7 - first read after load is dummy
// RULE8 - reads shift bits out msb first
// RULE9 - next byte prefetched during shifting
// RULE10 - branch replaces low fourteen address bits
// RULE11 - device loads at least two nibbles
// RULE12 - no branch with several roms
// RULE13 - write goes to fifo or command
// RULE14 - ready low once write byte latched
// RULE15 - read gives data or status register
// RULE16 - sixteen byte speech buffer
// RULE17 - buffer shifts out lsb of oldest
// RULE18 - stack pointer places new bytes above
// RULE19 - buffer low at eight empty bytes
// RULE20 - empty buffer flags and stops talk
// RULE21 - host reissues speak external after empty
// RULE22 - interrupt at speak external start; spr_dev_model pulls intN low then only if be was low
// RULE23 - interrupt on buffer flag rising
// RULE24 - talk starts after nine bytes
// RULE25 - selects idle between ops, clock aligned
module spr_host #(
    parameter int ROM_BYTES = 16384,               // bytes in this rom
    parameter logic [3:0] CHIP_ID = 4'h0            // chip select this rom answers
) (
    input  wire logic                       ref_clk,        // host clock
    input  wire logic                       rst,            // synchronous reset
    input  wire logic                       ce,             // clock enable
    // user command port
    input  wire logic                       userValid,      // request strobe
    input  wire logic                       userWrite,      // 1 write, 0 read
    input  wire logic                       userIsData,     // write is speech data
    input  wire logic [spr_pkg::BUS_W-1:0]  userData,       // byte to write
    output logic                            userBusy,       // cycle in progress
    output logic                            userRefused,    // data write refused
    output logic                            rdValid,        // read byte ready
    output logic [spr_pkg::BUS_W-1:0]       rdData,         // byte read back
    output logic                            extActive,      // external speech on
    output logic                            intSeen,        // interrupt line low
    // processor cpu bus
    output logic                            write_select_n, // write strobe
    output logic                            read_select_n,  // read strobe
    output logic [spr_pkg::BUS_W-1:0]       busOut,         // data we drive
    output logic                            busOe,          // low while driving
    input  wire logic [spr_pkg::BUS_W-1:0]  busIn,          // bus level
    input  wire logic                       readyN,         // device ready
    input  wire logic                       intN,           // device interrupt
    // rom image load, ref_clk domain
    input  wire logic                       romWe,          // write one rom byte
    input  wire logic [13:0]                romWaddr,       // rom byte address
    input  wire logic [7:0]                 romWdata,       // rom byte value
    // speech rom pins, rom clock domain
    input  wire logic                       memory_sync_clock,  // rom clock
    input  wire logic                       rom_function_sel_a, // read select
    input  wire logic                       rom_function_sel_b, // load select
    input  wire logic [3:0]                 nibbleIn,       // nibble bus level
    output logic                            nibble_msb_data_line, // rom data out
    output logic                            romOe           // low while driving
);
    import spr_pkg::*;

    // ************************************************************
    // input synchronisers, ref_clk domain
    // ************************************************************
    logic [BUS_W-1:0] busS1_reg, busS2_reg;        // bus sample stages
    logic             rdyS1_reg, rdyS2_reg;        // ready stages
    logic             intS1_reg, intS2_reg;        // interrupt stages

    // two flops before any logic reads a pin
    always_ff @(posedge ref_clk) begin
        if (ce) begin
            busS1_reg <= busIn;
            busS2_reg <= busS1_reg;
            rdyS1_reg <= readyN;
            rdyS2_reg <= rdyS1_reg;
            intS1_reg <= intN;
            intS2_reg <= intS1_reg;
        end
    end

    // ************************************************************
    // host bus cycle engine
    // ************************************************************
    spr_state_e       state_reg, state_next;       // cycle state
    logic             isWrite_reg, isWrite_next;   // cycle kind
    logic             wsN_reg, wsN_next;           // write strobe
    logic             rsN_reg, rsN_next;           // read strobe
    logic [BUS_W-1:0] out_reg, out_next;           // driven byte
    logic             oe_reg, oe_next;             // bus enable, low drives
    logic             busy_reg, busy_next;         // busy flag
    logic             ref_reg, ref_next;           // refused pulse
    logic             rdv_reg, rdv_next;           // read valid pulse
    logic [BUS_W-1:0] rdd_reg, rdd_next;           // read byte
    logic             ext_reg, ext_next;           // external speech active
    logic             int_reg, int_next;           // interrupt seen

    // next values of the bus engine
    always_comb begin
        state_next   = state_reg;
        isWrite_next = isWrite_reg;
        wsN_next     = wsN_reg;
        rsN_next     = rsN_reg;
        out_next     = out_reg;
        oe_next      = oe_reg;
        ref_next     = 1'b0;
        rdv_next     = 1'b0;
        rdd_next     = rdd_reg;
        ext_next     = ext_reg;
        int_next     = !intS2_reg;                  // RULE23
        unique case (state_reg)
            SPR_IDLE: begin
                if (userValid && userWrite && userIsData && !ext_reg) begin
                    ref_next = 1'b1;                // RULE21
                end else if (userValid) begin
                    isWrite_next = userWrite;
                    wsN_next     = !userWrite;
                    rsN_next     = userWrite;
                    out_next     = userData;
                    oe_next      = !userWrite;      // drive only on writes
                    if (userWrite && !userIsData &&
                        userData[CMD_LSB+2:CMD_LSB] == CMD_SPK_EXT) begin
                        ext_next = 1'b1;            // RULE13
                    end
                    state_next = SPR_WAITH;
                end
            end
            SPR_WAITH: begin
                // ready rises once the device has seen the strobe
                if (rdyS2_reg) begin
                    state_next = SPR_WAITL;
                end
            end
            SPR_WAITL: begin
                // ready low: byte latched or read data stable
                if (!rdyS2_reg) begin               // RULE14
                    if (!isWrite_reg) begin
                        rdv_next = 1'b1;            // RULE15
                        rdd_next = busS2_reg;
                        if (busS2_reg[STAT_BE_BIT]) begin
                            ext_next = 1'b0;        // RULE20
                        end
                    end
                    wsN_next   = 1'b1;
                    rsN_next   = 1'b1;
                    state_next = SPR_DONE;
                end
            end
            SPR_DONE: begin
                // release the bus one cycle after the strobes
                oe_next    = 1'b1;
                state_next = SPR_IDLE;
            end
        endcase
        busy_next = (state_next != SPR_IDLE);
    end

    // registers of the bus engine
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg   <= SPR_IDLE;
            isWrite_reg <= 1'b0;
            wsN_reg     <= 1'b1;
            rsN_reg     <= 1'b1;
            out_reg     <= BUS_RESET;
            oe_reg      <= 1'b1;
            busy_reg    <= 1'b0;
            ref_reg     <= 1'b0;
            rdv_reg     <= 1'b0;
            rdd_reg     <= BUS_RESET;
            ext_reg     <= 1'b0;
            int_reg     <= 1'b0;
        end else if (ce) begin
            state_reg   <= state_next;
            isWrite_reg <= isWrite_next;
            wsN_reg     <= wsN_next;
            rsN_reg     <= rsN_next;
            out_reg     <= out_next;
            oe_reg      <= oe_next;
            busy_reg    <= busy_next;
            ref_reg     <= ref_next;
            rdv_reg     <= rdv_next;
            rdd_reg     <= rdd_next;
            ext_reg     <= ext_next;
            int_reg     <= int_next;
        end
    end

    assign write_select_n = wsN_reg;
    assign read_select_n  = rsN_reg;
    assign busOut         = out_reg;
    assign busOe          = oe_reg;
    assign userBusy       = busy_reg;
    assign userRefused    = ref_reg;
    assign rdValid        = rdv_reg;
    assign rdData         = rdd_reg;
    assign extActive      = ext_reg;
    assign intSeen        = int_reg;

    // ************************************************************
    // speech rom, rom clock domain
    // ************************************************************
    logic [7:0]        romMem [ROM_BYTES];         // rom image
    logic              rstR1_reg, rstR2_reg;       // reset into rom domain

    // image written from ref_clk only; read on the rom clock
    always_ff @(posedge ref_clk) begin
        if (ce && romWe) begin
            romMem[romWaddr] <= romWdata;
        end
    end

    // reset level crossing
    always_ff @(posedge memory_sync_clock) begin
        rstR1_reg <= rst;
        rstR2_reg <= rstR1_reg;
    end

    logic [ADDR_W-1:0] addr_reg, addr_next;        // address register
    logic [2:0]        ptr_reg, ptr_next;          // load pointer
    logic              dummy_reg, dummy_next;      // next read is dummy
    logic [7:0]        cur_reg, cur_next;          // byte being shifted
    logic [2:0]        bit_reg, bit_next;          // bit index
    logic              dout_reg, dout_next;        // data line value
    logic              roe_reg, roe_next;          // line enable, low drives
    logic [1:0]        fn;                         // decoded function
    logic              sel;                        // chip select matches
    logic [15:0]       word;                       // branch word
    logic [13:0]       curAdr;                     // address of byte now shifting

    // next values of the rom
    always_comb begin
        fn         = {rom_function_sel_a, rom_function_sel_b};  // RULE5
        sel        = (addr_reg[CS_LSB +: CS_W] == CHIP_ID);     // RULE3
        // the counter already points past the prefetched byte, so the
        // branch word starts one location back, low byte first
        curAdr     = addr_reg[BYTE_ADDR_W-1:0] - 14'h1;
        word       = {romMem[addr_reg[BYTE_ADDR_W-1:0]],
                      romMem[curAdr]};
        addr_next  = addr_reg;
        ptr_next   = ptr_reg;
        dummy_next = dummy_reg;
        cur_next   = cur_reg;
        bit_next   = bit_reg;
        dout_next  = dout_reg;
        roe_next   = roe_reg;
        unique case (fn)
            FN_IDLE: begin
                // hold line state between reads
            end
            FN_LOAD: begin
                addr_next[{ptr_reg, 2'h0} +: 4] = nibbleIn;    // RULE6
                ptr_next   = (ptr_reg == 3'(NIBBLES - 1)) ? PTR_RESET : ptr_reg + 3'h1;
                dummy_next = 1'b1;
                roe_next   = 1'b1;                  // RULE2
            end
            FN_READ: begin
                if (dummy_reg) begin
                    ptr_next   = PTR_RESET;         // RULE7
                    dummy_next = 1'b0;
                    cur_next   = romMem[addr_reg[BYTE_ADDR_W-1:0]];
                    addr_next[BYTE_ADDR_W-1:0] = addr_reg[BYTE_ADDR_W-1:0] + 14'h1;
                    bit_next   = BIT_MSB;
                end else begin
                    dout_next = cur_reg[bit_reg];   // RULE8
                    roe_next  = !sel;               // RULE2
                    bit_next  = bit_reg - 3'h1;
                    if (bit_reg == 3'h0) begin
                        // RULE4 RULE9
                        cur_next = romMem[addr_reg[BYTE_ADDR_W-1:0]];
                        addr_next[BYTE_ADDR_W-1:0] = addr_reg[BYTE_ADDR_W-1:0] + 14'h1;
                    end
                end
            end
            FN_BRANCH: begin
                addr_next[BYTE_ADDR_W-1:0] = word[BYTE_ADDR_W-1:0] + 14'h1;  // RULE10
                cur_next   = romMem[word[BYTE_ADDR_W-1:0]];
                ptr_next   = PTR_RESET;
                dummy_next = 1'b0;
                bit_next   = BIT_MSB;
            end
        endcase
    end

    // registers of the rom
    always_ff @(posedge memory_sync_clock) begin
        if (rstR2_reg) begin
            addr_reg  <= ADDR_RESET;
            ptr_reg   <= PTR_RESET;
            dummy_reg <= 1'b1;
            cur_reg   <= 8'h00;
            bit_reg   <= BIT_MSB;
            dout_reg  <= 1'b0;
            roe_reg   <= 1'b1;
        end else begin
            addr_reg  <= addr_next;
            ptr_reg   <= ptr_next;
            dummy_reg <= dummy_next;
            cur_reg   <= cur_next;
            bit_reg   <= bit_next;
            dout_reg  <= dout_next;
            roe_reg   <= roe_next;
        end
    end

    assign nibble_msb_data_line = dout_reg;
    assign romOe                = roe_reg;
endmodule

//--- verilog/spr_pkg.sv
// Purpose : constants shared by the speech-port host controller
// Assumes : host bus bit 7 carries the device's D0 (most significant) line
// Notes   : command codes sit in the three bits just below D0
package spr_pkg;
    // ************************************************************
    // host bus layout
    // ************************************************************
    localparam int          BUS_W        = 8;       // host data bus width
    localparam int          CMD_LSB      = 4;       // command code field low bit
    localparam logic [2:0]  CMD_SPK_EXT  = 3'h6;    // speak external code
    localparam int          STAT_TS_BIT  = 7;       // talk status on D0
    localparam int          STAT_BL_BIT  = 6;       // buffer low on D1
    localparam int          STAT_BE_BIT  = 5;       // buffer empty on D2
    localparam logic [7:0]  BUS_RESET    = 8'h00;   // bus value after reset

    // ************************************************************
    // speech rom port
    // ************************************************************
    localparam int          ADDR_W       = 20;      // full rom address
    localparam int          BYTE_ADDR_W  = 14;      // byte select part
    localparam int          CS_LSB       = 14;      // chip select position
    localparam int          CS_W         = 4;       // chip select width
    localparam int          NIBBLES      = 5;       // loads per full address
    localparam logic [2:0]  PTR_RESET    = 3'h0;    // load pointer at lsb
    localparam logic [2:0]  BIT_MSB      = 3'h7;    // first bit shifted out
    localparam logic [ADDR_W-1:0] ADDR_RESET = 20'h00000;

    // function select encodings {a,b}
    localparam logic [1:0]  FN_IDLE      = 2'h0;
    localparam logic [1:0]  FN_LOAD      = 2'h1;
    localparam logic [1:0]  FN_READ      = 2'h2;
    localparam logic [1:0]  FN_BRANCH    = 2'h3;

    // host bus cycle states, gray along the path
    typedef enum logic [1:0] {
        SPR_IDLE  = 2'h0,
        SPR_WAITH = 2'h1,
        SPR_WAITL = 2'h3,
        SPR_DONE  = 2'h2
    } spr_state_e;
endpackage
